// file: rtl/cac_defines.svh
// cac_defines.svh: constants for the addressing corner-case execution block
// assumes it is included by bare name from cac_corner_exec
//
// What this block does
// RULE_01: address ops on program counter lose two bytes
// RULE_02: move immediate to program counter stays correct
// RULE_03: 20-bit push via stack autoincrement loads stack
// RULE_04: 20-bit call through program counter returns short
// RULE_05: stack-indexed call after memory push: no sign-extend
// RULE_06: only stack base and memory-mode push affected
// RULE_07: untaken conditional jump then rotate program counter halts
// RULE_08: bit test with indirect source to program counter skips opcode
// RULE_09: single-stepped interrupt disable or bit clear with interrupts enabled advances four bytes
// RULE_10: over-advance happens only while debug stepping
// RULE_11: all other combinations behave architecturally
`ifndef CAC_DEFINES_SVH
`define CAC_DEFINES_SVH

// register numbers
`define CAC_PC_REG 4'h0
`define CAC_SP_REG 4'h1
// byte counts used in address arithmetic
`define CAC_OPCODE_STEP 20'h00002
`define CAC_ADDR_OP_LEN 20'h00004
`define CAC_PUSH20_STEP 20'h00004
`define CAC_PUSH16_STEP 20'h00002
`define CAC_LOST_BYTES 20'h00002
`define CAC_STEP_OVERRUN 20'h00004
// reset values
`define CAC_ADDR_RST 20'h00000
`define CAC_FLAGS_RST 4'h0
// flag positions inside the flag nibble {v, n, z, c}
`define CAC_FLAG_C 0
`define CAC_FLAG_Z 1
`define CAC_FLAG_N 2
`define CAC_FLAG_V 3

`endif

// file: rtl/cac_pkg.sv
// cac_pkg: types for the addressing corner-case execution block
// assumes the decode stage ahead of this block fills these fields
package cac_pkg;

  // instruction classes seen by the execution block
  typedef enum logic [3:0] {
    CAC_OTHER = 4'h0,
    CAC_ADD_ADDRESS_OP = 4'h1,
    CAC_SUBTRACT_ADDRESS_OP = 4'h2,
    CAC_COMPARE_ADDRESS_OP = 4'h3,
    CAC_MOVE_OP = 4'h4,
    CAC_PUSH_20BIT_OP = 4'h5,
    CAC_PUSH_EXTENDED_OP = 4'h6,
    CAC_CALL_20BIT_OP = 4'h7,
    CAC_ROTATE_RIGHT_CARRY_MULTI = 4'h8,
    CAC_ROTATE_RIGHT_ARITH_MULTI = 4'h9,
    CAC_ROTATE_LEFT_ARITH_MULTI = 4'ha,
    CAC_ROTATE_RIGHT_UNSIGNED_MULTI = 4'hb,
    CAC_COND_JUMP = 4'hc,
    CAC_BIT_TEST_OP = 4'hd,
    CAC_DISABLE_INTERRUPTS_OP = 4'he,
    CAC_BIT_CLEAR_OP = 4'hf
  } cac_op_type;

  // source addressing modes
  typedef enum logic [2:0] {
    CAC_MODE_REGISTER = 3'h0,
    CAC_MODE_INDEXED = 3'h1,
    CAC_MODE_SYMBOLIC = 3'h2,
    CAC_MODE_ABSOLUTE = 3'h3,
    CAC_MODE_INDIRECT = 3'h4,
    CAC_MODE_AUTOINC = 3'h5,
    CAC_MODE_IMMEDIATE = 3'h6
  } cac_mode_type;

  // conditional jump kinds
  typedef enum logic [2:0] {
    CAC_JUMP_IF_ZERO = 3'h0,
    CAC_JUMP_IF_NONZERO = 3'h1,
    CAC_JUMP_IF_CARRY = 3'h2,
    CAC_JUMP_IF_NO_CARRY = 3'h3,
    CAC_JUMP_IF_NEGATIVE = 3'h4,
    CAC_JUMP_IF_GREATER_EQUAL = 3'h5,
    CAC_JUMP_IF_LESS = 3'h6,
    CAC_JUMP_ALWAYS = 3'h7
  } cac_cond_type;

  // run state of the core
  typedef enum logic [0:0] {
    CAC_RUN = 1'b0,
    CAC_HALTED = 1'b1
  } cac_state_type;

endpackage

// file: rtl/cac_prev_track.sv
// cac_prev_track: remembers what the previously retired instruction was
// assumes accept is a one-cycle strobe from the execution block on the same clock
`timescale 1ns/1ns

module cac_prev_track (
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // retiring instruction
  input wire logic accept_i,
  input wire logic push_mem_i,
  input wire logic jump_skip_i,
  // history
  output logic prev_push_mem_o,
  output logic prev_jump_skip_o
);

  // history is replaced by every retired instruction, so a nop clears it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev_push_mem_o <= 1'b0;
      prev_jump_skip_o <= 1'b0;
    end else if (ce_i && accept_i) begin
      prev_push_mem_o <= push_mem_i;
      prev_jump_skip_o <= jump_skip_i;
    end
  end

endmodule

// file: rtl/cac_corner_exec.sv
// cac_corner_exec: program counter, stack pointer and flag outcome of one instruction,
// including the known misbehaviour of this core in some addressing combinations
// assumes decode and operand fetch run ahead on the same clock and present one
// instruction per INSTR_VALID_I strobe; results appear one cycle later
`timescale 1ns/1ns
`include "cac_defines.svh"

module cac_corner_exec (
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // decoded instruction
  input wire logic INSTR_VALID_I,
  input wire cac_pkg::cac_op_type OP_I,
  input wire cac_pkg::cac_mode_type SRC_MODE_I,
  input wire logic [3:0] SRC_REG_I,
  input wire logic [3:0] DST_REG_I,
  input wire cac_pkg::cac_cond_type COND_I,
  input wire logic BYTE_I,
  input wire logic [2:0] INSTR_LEN_I,
  input wire logic [19:0] INSTR_ADDR_I,
  input wire logic [19:0] IMM_I,
  // operand values
  input wire logic [19:0] SRC_DATA_I,
  input wire logic [19:0] REG_DATA_I,
  input wire logic [19:0] DST_DATA_I,
  input wire logic [19:0] SP_I,
  input wire logic [3:0] FLAGS_I,
  // debug and interrupt state
  input wire logic STEP_I,
  input wire logic GLOBAL_INTERRUPT_ENABLE_I,
  // results
  output logic DONE_O,
  output logic [19:0] NEXT_PC_O,
  output logic [19:0] NEXT_SP_O,
  output logic PUSH_EN_O,
  output logic [19:0] PUSH_DATA_O,
  output logic [19:0] EFF_ADDR_O,
  output logic RESULT_EN_O,
  output logic [19:0] RESULT_O,
  output logic FLAGS_EN_O,
  output logic [3:0] FLAGS_O,
  output logic HALT_O
);
  import cac_pkg::*;

  cac_state_type state;
  logic accept;
  logic prev_push_mem;
  logic prev_jump_skip;
  logic is_push_mem;
  logic is_jump_skip;
  logic is_rotate;
  logic dst_pc;
  logic next_halt;
  logic [19:0] next_pc;
  logic [19:0] next_sp;
  logic next_push_en;
  logic [19:0] next_push_data;
  logic [19:0] next_ea;
  logic next_result_en;
  logic [19:0] next_result;
  logic next_flags_en;
  logic [3:0] next_flags;

  // 20-bit add or subtract with {v, n, z, c} flags above the sum
  function automatic logic [23:0] addr_arith(input logic [19:0] a, input logic [19:0] b, input logic sub);
    logic [20:0] full;
    logic [19:0] bb;
    logic [3:0] f;
    bb = sub ? ~b : b;
    full = {1'b0, a} + {1'b0, bb} + {20'h00000, sub};
    f[`CAC_FLAG_C] = full[20];
    f[`CAC_FLAG_Z] = (full[19:0] == 20'h00000);
    f[`CAC_FLAG_N] = full[19];
    f[`CAC_FLAG_V] = (a[19] == bb[19]) && (full[19] != a[19]);
    return {f, full[19:0]};
  endfunction

  // multi-bit rotate of an address, count 1 to 4 from the low bits of the immediate
  function automatic logic [20:0] rotate_addr(input cac_op_type op, input logic [19:0] v, input logic [1:0] cnt,
                                              input logic cin);
    logic [19:0] r;
    logic c;
    r = v;
    c = cin;
    for (int i = 0; i < 4; i++) begin
      if (i <= int'(cnt)) begin
        case (op)
          CAC_ROTATE_RIGHT_CARRY_MULTI: begin
            {r, c} = {c, r};
          end
          CAC_ROTATE_RIGHT_ARITH_MULTI: begin
            c = r[0];
            r = {r[19], r[19:1]};
          end
          CAC_ROTATE_LEFT_ARITH_MULTI: begin
            c = r[19];
            r = {r[18:0], 1'b0};
          end
          default: begin
            c = r[0];
            r = {1'b0, r[19:1]};
          end
        endcase
      end
    end
    return {c, r};
  endfunction

  // jump condition from the incoming status flags
  function automatic logic cond_true(input cac_cond_type cond, input logic [3:0] f);
    case (cond)
      CAC_JUMP_IF_ZERO: cond_true = f[`CAC_FLAG_Z];
      CAC_JUMP_IF_NONZERO: cond_true = !f[`CAC_FLAG_Z];
      CAC_JUMP_IF_CARRY: cond_true = f[`CAC_FLAG_C];
      CAC_JUMP_IF_NO_CARRY: cond_true = !f[`CAC_FLAG_C];
      CAC_JUMP_IF_NEGATIVE: cond_true = f[`CAC_FLAG_N];
      CAC_JUMP_IF_GREATER_EQUAL: cond_true = (f[`CAC_FLAG_N] == f[`CAC_FLAG_V]);
      CAC_JUMP_IF_LESS: cond_true = (f[`CAC_FLAG_N] != f[`CAC_FLAG_V]);
      default: cond_true = 1'b1;
    endcase
  endfunction

  // a halted core takes nothing further until reset
  assign accept = INSTR_VALID_I && CE_I && (state == CAC_RUN);
  assign dst_pc = (DST_REG_I == `CAC_PC_REG);
  assign is_rotate = (OP_I == CAC_ROTATE_RIGHT_CARRY_MULTI) || (OP_I == CAC_ROTATE_RIGHT_ARITH_MULTI) ||
                     (OP_I == CAC_ROTATE_LEFT_ARITH_MULTI) || (OP_I == CAC_ROTATE_RIGHT_UNSIGNED_MULTI);
  // RULE_06: memory-mode push only
  assign is_push_mem = ((OP_I == CAC_PUSH_20BIT_OP) || (OP_I == CAC_PUSH_EXTENDED_OP)) &&
                       (SRC_MODE_I != CAC_MODE_REGISTER) && (SRC_MODE_I != CAC_MODE_IMMEDIATE);
  assign is_jump_skip = (OP_I == CAC_COND_JUMP) && !cond_true(COND_I, FLAGS_I);
  // RULE_07: rotate after skip
  assign next_halt = is_rotate && dst_pc && prev_jump_skip;

  // history of the previous retired instruction lives apart from the datapath
  cac_prev_track u_cac_prev_track (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .accept_i(accept),
    .push_mem_i(is_push_mem),
    .jump_skip_i(is_jump_skip),
    .prev_push_mem_o(prev_push_mem),
    .prev_jump_skip_o(prev_jump_skip)
  );

  // outcome of the presented instruction
  always_comb begin
    logic [19:0] fall;
    logic [19:0] pc_base;
    logic [19:0] idx;
    logic [19:0] masked;
    logic [23:0] ar;
    logic [20:0] rot;
    fall = INSTR_ADDR_I + {17'h00000, INSTR_LEN_I};
    pc_base = INSTR_ADDR_I;
    idx = 20'h00000;
    masked = 20'h00000;
    ar = 24'h000000;
    rot = 21'h000000;
    next_pc = fall;
    next_sp = SP_I;
    next_push_en = 1'b0;
    next_push_data = 20'h00000;
    next_ea = 20'h00000;
    next_result_en = 1'b0;
    next_result = 20'h00000;
    next_flags_en = 1'b0;
    next_flags = FLAGS_I;
    case (OP_I)
      CAC_ADD_ADDRESS_OP, CAC_SUBTRACT_ADDRESS_OP, CAC_COMPARE_ADDRESS_OP: begin
        // RULE_01: two opcode bytes lost
        pc_base = INSTR_ADDR_I + `CAC_ADDR_OP_LEN - `CAC_LOST_BYTES;
        ar = addr_arith(dst_pc ? pc_base : DST_DATA_I, IMM_I, OP_I != CAC_ADD_ADDRESS_OP);
        next_flags_en = 1'b1;
        next_flags = ar[23:20];
        if (OP_I != CAC_COMPARE_ADDRESS_OP) begin
          if (dst_pc) begin
            next_pc = ar[19:0];
          end else begin
            next_result_en = 1'b1;
            next_result = ar[19:0];
          end
        end
      end
      CAC_MOVE_OP: begin
        // RULE_02: move immediate exact
        if (dst_pc) begin
          next_pc = SRC_DATA_I;
        end else begin
          next_result_en = 1'b1;
          next_result = SRC_DATA_I;
        end
      end
      CAC_PUSH_20BIT_OP, CAC_PUSH_EXTENDED_OP: begin
        next_push_en = 1'b1;
        next_push_data = SRC_DATA_I;
        next_ea = SP_I - ((OP_I == CAC_PUSH_20BIT_OP) ? `CAC_PUSH20_STEP : `CAC_PUSH16_STEP);
        next_sp = next_ea;
        // RULE_03: stack loaded from memory
        if ((OP_I == CAC_PUSH_20BIT_OP) && (SRC_MODE_I == CAC_MODE_AUTOINC) && (SRC_REG_I == `CAC_SP_REG)) begin
          next_sp = SRC_DATA_I;
        end
      end
      CAC_CALL_20BIT_OP: begin
        next_sp = SP_I - `CAC_PUSH20_STEP;
        next_push_en = 1'b1;
        next_push_data = fall;
        next_pc = SRC_DATA_I;
        if (SRC_MODE_I == CAC_MODE_REGISTER) begin
          next_pc = REG_DATA_I;
          if (SRC_REG_I == `CAC_PC_REG) begin
            // RULE_04: return address two short
            next_pc = INSTR_ADDR_I + `CAC_OPCODE_STEP;
            next_push_data = fall - `CAC_LOST_BYTES;
          end
        end else if (SRC_MODE_I == CAC_MODE_INDEXED) begin
          idx = {{4{IMM_I[15]}}, IMM_I[15:0]};
          // RULE_05: index kept unsigned
          // RULE_06: only stack base after memory push
          if ((SRC_REG_I == `CAC_SP_REG) && prev_push_mem) begin
            idx = {4'h0, IMM_I[15:0]};
          end
          next_ea = REG_DATA_I + idx;
        end
      end
      CAC_ROTATE_RIGHT_CARRY_MULTI, CAC_ROTATE_RIGHT_ARITH_MULTI, CAC_ROTATE_LEFT_ARITH_MULTI,
      CAC_ROTATE_RIGHT_UNSIGNED_MULTI: begin
        // RULE_11: ordinary address rotate
        rot = rotate_addr(OP_I, dst_pc ? INSTR_ADDR_I + `CAC_OPCODE_STEP : DST_DATA_I, IMM_I[1:0],
                          FLAGS_I[`CAC_FLAG_C]);
        next_flags_en = 1'b1;
        next_flags = {1'b0, rot[19], (rot[19:0] == 20'h00000), rot[20]};
        if (dst_pc) begin
          next_pc = rot[19:0];
        end else begin
          next_result_en = 1'b1;
          next_result = rot[19:0];
        end
      end
      CAC_COND_JUMP: begin
        // ten-bit word offset from the following instruction
        if (cond_true(COND_I, FLAGS_I)) begin
          next_pc = INSTR_ADDR_I + `CAC_OPCODE_STEP + {{9{IMM_I[9]}}, IMM_I[9:0], 1'b0};
        end
      end
      CAC_BIT_TEST_OP: begin
        // RULE_08: indirect source, program counter without opcode
        pc_base = (dst_pc && (SRC_MODE_I == CAC_MODE_INDIRECT)) ? INSTR_ADDR_I :
                  (dst_pc ? INSTR_ADDR_I + `CAC_OPCODE_STEP : DST_DATA_I);
        masked = SRC_DATA_I & pc_base & (BYTE_I ? 20'h000ff : 20'h0ffff);
        next_flags_en = 1'b1;
        next_flags[`CAC_FLAG_Z] = (masked == 20'h00000);
        next_flags[`CAC_FLAG_C] = (masked != 20'h00000);
        next_flags[`CAC_FLAG_N] = BYTE_I ? masked[7] : masked[15];
        next_flags[`CAC_FLAG_V] = 1'b0;
      end
      CAC_DISABLE_INTERRUPTS_OP, CAC_BIT_CLEAR_OP: begin
        // RULE_09: stepped disable overruns
        // RULE_10: debug stepping only
        if (STEP_I && GLOBAL_INTERRUPT_ENABLE_I) begin
          next_pc = INSTR_ADDR_I + `CAC_STEP_OVERRUN;
        end
      end
      default: begin
        // RULE_11: plain fall-through
        next_pc = fall;
      end
    endcase
  end

  // run state: the skip-then-rotate pair locks the core until reset
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state <= CAC_RUN;
      HALT_O <= 1'b0;
    end else if (accept && next_halt) begin
      state <= CAC_HALTED;
      HALT_O <= 1'b1;
    end
  end

  // retire strobe; a halting instruction never retires
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      DONE_O <= 1'b0;
    end else if (CE_I) begin
      DONE_O <= accept && !next_halt;
    end
  end

  // result registers hold their last value between strobes
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      NEXT_PC_O <= `CAC_ADDR_RST;
      NEXT_SP_O <= `CAC_ADDR_RST;
      PUSH_EN_O <= 1'b0;
      PUSH_DATA_O <= `CAC_ADDR_RST;
      EFF_ADDR_O <= `CAC_ADDR_RST;
      RESULT_EN_O <= 1'b0;
      RESULT_O <= `CAC_ADDR_RST;
      FLAGS_EN_O <= 1'b0;
      FLAGS_O <= `CAC_FLAGS_RST;
    end else if (accept && !next_halt) begin
      NEXT_PC_O <= next_pc;
      NEXT_SP_O <= next_sp;
      PUSH_EN_O <= next_push_en;
      PUSH_DATA_O <= next_push_data;
      EFF_ADDR_O <= next_ea;
      RESULT_EN_O <= next_result_en;
      RESULT_O <= next_result;
      FLAGS_EN_O <= next_flags_en;
      FLAGS_O <= next_flags;
    end
  end

endmodule

// file: testbench/cac_corner_exec_sva.sv
// cac_corner_exec_sva: port-level checks of the corner-case executor
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns

module cac_corner_exec_sva (
  // clock and control
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  // instruction
  input wire logic INSTR_VALID_I,
  input wire cac_pkg::cac_op_type OP_I,
  input wire cac_pkg::cac_mode_type SRC_MODE_I,
  input wire logic [3:0] SRC_REG_I,
  input wire logic [3:0] DST_REG_I,
  input wire logic [2:0] INSTR_LEN_I,
  input wire logic [19:0] INSTR_ADDR_I,
  input wire logic [19:0] IMM_I,
  input wire logic [19:0] SRC_DATA_I,
  input wire logic STEP_I,
  input wire logic GLOBAL_INTERRUPT_ENABLE_I,
  // results
  input wire logic DONE_O,
  input wire logic [19:0] NEXT_PC_O,
  input wire logic [19:0] NEXT_SP_O,
  input wire logic [19:0] PUSH_DATA_O,
  input wire logic HALT_O
);
  import cac_pkg::*;
  logic take;
  logic pc_dst;
  // an instruction only counts when enabled and not halted
  assign take = INSTR_VALID_I && CE_I && !HALT_O;
  assign pc_dst = DST_REG_I == 4'h0;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  answer_once_a:
    assert property (take |=> DONE_O != HALT_O) else $error("taken instruction not answered");
  refuse_idle_a:
    assert property (!take && CE_I |=> !DONE_O) else $error("done without a taken instruction");
  halt_cause_a:
    assert property ($rose(HALT_O) |-> $past(take && pc_dst && OP_I inside {CAC_ROTATE_RIGHT_CARRY_MULTI,
      CAC_ROTATE_RIGHT_ARITH_MULTI, CAC_ROTATE_LEFT_ARITH_MULTI, CAC_ROTATE_RIGHT_UNSIGNED_MULTI}))
      else $error("halt without rotate to pc");
  halt_hold_a:
    assert property (HALT_O |=> HALT_O) else $error("halt dropped");
  add_addr_pc_a:
    assert property (take && OP_I == CAC_ADD_ADDRESS_OP && SRC_MODE_I == CAC_MODE_IMMEDIATE && pc_dst
      |=> NEXT_PC_O == $past(INSTR_ADDR_I) + 20'h00002 + $past(IMM_I)) else $error("add address pc wrong");
  move_pc_a:
    assert property (take && OP_I == CAC_MOVE_OP && SRC_MODE_I == CAC_MODE_IMMEDIATE && pc_dst
      |=> NEXT_PC_O == $past(SRC_DATA_I)) else $error("move to pc wrong");
  push_sp_a:
    assert property (take && OP_I == CAC_PUSH_20BIT_OP && SRC_MODE_I == CAC_MODE_AUTOINC && SRC_REG_I == 4'h1
      |=> NEXT_SP_O == $past(SRC_DATA_I)) else $error("push through stack sp wrong");
  call_ret_a:
    assert property (take && OP_I == CAC_CALL_20BIT_OP && SRC_MODE_I == CAC_MODE_REGISTER && SRC_REG_I == 4'h0
      |=> PUSH_DATA_O == $past(INSTR_ADDR_I) + {17'h0, $past(INSTR_LEN_I)} - 20'h00002)
      else $error("call pc return wrong");
  step_pc_a:
    assert property (take && OP_I inside {CAC_DISABLE_INTERRUPTS_OP, CAC_BIT_CLEAR_OP}
      |=> NEXT_PC_O == $past(INSTR_ADDR_I) + ($past(STEP_I && GLOBAL_INTERRUPT_ENABLE_I) ? 20'h00004 :
      {17'h0, $past(INSTR_LEN_I)}))
      else $error("interrupt disable pc wrong");
  // main scenarios reached
  cover property (take ##1 HALT_O);
  cover property (take && OP_I == CAC_CALL_20BIT_OP);
  cover property (take && STEP_I && GLOBAL_INTERRUPT_ENABLE_I);
endmodule

bind cac_corner_exec cac_corner_exec_sva u_cac_corner_exec_sva (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .INSTR_VALID_I(INSTR_VALID_I), .OP_I(OP_I),
  .SRC_MODE_I(SRC_MODE_I), .SRC_REG_I(SRC_REG_I), .DST_REG_I(DST_REG_I), .INSTR_LEN_I(INSTR_LEN_I),
  .INSTR_ADDR_I(INSTR_ADDR_I), .IMM_I(IMM_I), .SRC_DATA_I(SRC_DATA_I), .STEP_I(STEP_I),
  .GLOBAL_INTERRUPT_ENABLE_I(GLOBAL_INTERRUPT_ENABLE_I), .DONE_O(DONE_O), .NEXT_PC_O(NEXT_PC_O),
  .NEXT_SP_O(NEXT_SP_O), .PUSH_DATA_O(PUSH_DATA_O), .HALT_O(HALT_O)
);

// file: testbench/cac_corner_exec_tb.sv
// cac_corner_exec_tb: table-driven and hand-written checks of the corner-case executor
// assumes results show one cycle after each taken instruction
`timescale 1ns/1ns

module cac_corner_exec_tb;
  import cac_pkg::*;
  typedef struct {
    cac_op_type op;
    cac_mode_type md;
    logic [3:0] sr;
    logic [3:0] dr;
    cac_cond_type cd;
    logic [3:0] fl;
    logic [2:0] ln;
    logic [19:0] im;
    logic [19:0] sd;
    logic st;
    logic ge;
    logic [19:0] pc;
    logic [19:0] sp;
    logic [2:0] en;
  } cac_row_type;
  logic CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic CE_I = 1'b1;
  logic INSTR_VALID_I = 1'b0;
  cac_op_type OP_I = CAC_OTHER;
  cac_mode_type SRC_MODE_I = CAC_MODE_REGISTER;
  cac_cond_type COND_I = CAC_JUMP_IF_ZERO;
  logic [3:0] SRC_REG_I = 4'h0;
  logic [3:0] DST_REG_I = 4'h0;
  logic BYTE_I = 1'b0;
  logic [2:0] INSTR_LEN_I = 3'h2;
  logic [19:0] INSTR_ADDR_I = 20'h01000;
  logic [19:0] IMM_I = 20'h0;
  logic [19:0] SRC_DATA_I = 20'h0;
  logic [19:0] REG_DATA_I = 20'h02000;
  logic [19:0] DST_DATA_I = 20'h0;
  logic [19:0] SP_I = 20'h03000;
  logic [3:0] FLAGS_I = 4'h0;
  logic STEP_I = 1'b0;
  logic GLOBAL_INTERRUPT_ENABLE_I = 1'b0;
  logic DONE_O, PUSH_EN_O, RESULT_EN_O, FLAGS_EN_O, HALT_O;
  logic [19:0] NEXT_PC_O, NEXT_SP_O, PUSH_DATA_O, EFF_ADDR_O, RESULT_O;
  logic [3:0] FLAGS_O;
  int miscompares = 0;
  int samples_checked = 0;
  cac_row_type rows [12];
  cac_row_type r;
  cac_mode_type pm [5] = '{CAC_MODE_ABSOLUTE, CAC_MODE_REGISTER, CAC_MODE_AUTOINC, CAC_MODE_INDIRECT,
    CAC_MODE_IMMEDIATE};
  logic [3:0] bs [5] = '{4'h1, 4'h1, 4'h5, 4'h1, 4'h1};
  logic [19:0] ex [5] = '{20'h11ff0, 20'h01ff0, 20'h01ff0, 20'h11ff0, 20'h01ff0};
  logic [3:0] nf [7] = '{4'h0, 4'h2, 4'h0, 4'h1, 4'h0, 4'h4, 4'h0};

  cac_corner_exec u_cac_corner_exec (
    .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .INSTR_VALID_I(INSTR_VALID_I), .OP_I(OP_I),
    .SRC_MODE_I(SRC_MODE_I), .SRC_REG_I(SRC_REG_I), .DST_REG_I(DST_REG_I), .COND_I(COND_I), .BYTE_I(BYTE_I),
    .INSTR_LEN_I(INSTR_LEN_I), .INSTR_ADDR_I(INSTR_ADDR_I), .IMM_I(IMM_I), .SRC_DATA_I(SRC_DATA_I),
    .REG_DATA_I(REG_DATA_I), .DST_DATA_I(DST_DATA_I), .SP_I(SP_I), .FLAGS_I(FLAGS_I), .STEP_I(STEP_I),
    .GLOBAL_INTERRUPT_ENABLE_I(GLOBAL_INTERRUPT_ENABLE_I), .DONE_O(DONE_O), .NEXT_PC_O(NEXT_PC_O),
    .NEXT_SP_O(NEXT_SP_O), .PUSH_EN_O(PUSH_EN_O),
    .PUSH_DATA_O(PUSH_DATA_O), .EFF_ADDR_O(EFF_ADDR_O), .RESULT_EN_O(RESULT_EN_O), .RESULT_O(RESULT_O),
    .FLAGS_EN_O(FLAGS_EN_O), .FLAGS_O(FLAGS_O), .HALT_O(HALT_O)
  );

  // 100 MHz clock
  always #5 CLK_I = ~CLK_I;

  task automatic chk1(input string nm, input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk20(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // present one instruction; returns just after the edge that takes it
  task automatic send(input cac_row_type x);
    OP_I = x.op;
    SRC_MODE_I = x.md;
    SRC_REG_I = x.sr;
    DST_REG_I = x.dr;
    COND_I = x.cd;
    FLAGS_I = x.fl;
    INSTR_LEN_I = x.ln;
    IMM_I = x.im;
    SRC_DATA_I = x.sd;
    STEP_I = x.st;
    GLOBAL_INTERRUPT_ENABLE_I = x.ge;
    INSTR_VALID_I = 1'b1;
    @(posedge CLK_I);
    #1;
  endtask

  // halt is sticky, so every halt scenario ends here
  task automatic rst;
    SRST_I = 1'b1;
    INSTR_VALID_I = 1'b0;
    repeat (20) @(posedge CLK_I);
    #1;
    SRST_I = 1'b0;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end

  initial begin
    // enables column is {push, result, flags}
    rows = '{
      '{CAC_ADD_ADDRESS_OP,CAC_MODE_IMMEDIATE,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h4,20'h10,20'h0,
        1'b0,1'b0,20'h01012,20'h03000,3'h1},
      '{CAC_SUBTRACT_ADDRESS_OP,CAC_MODE_IMMEDIATE,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h4,20'h10,20'h0,
        1'b0,1'b0,20'h00ff2,20'h03000,3'h1},
      '{CAC_COMPARE_ADDRESS_OP,CAC_MODE_IMMEDIATE,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h4,20'h10,20'h0,
        1'b0,1'b0,20'h01004,20'h03000,3'h1},
      '{CAC_MOVE_OP,CAC_MODE_IMMEDIATE,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h4,20'h23456,20'h23456,
        1'b0,1'b0,20'h23456,20'h03000,3'h0},
      '{CAC_PUSH_20BIT_OP,CAC_MODE_AUTOINC,4'h1,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0abcd,
        1'b0,1'b0,20'h01002,20'h0abcd,3'h4},
      '{CAC_PUSH_20BIT_OP,CAC_MODE_REGISTER,4'h5,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0,
        1'b0,1'b0,20'h01002,20'h02ffc,3'h4},
      '{CAC_DISABLE_INTERRUPTS_OP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0,
        1'b1,1'b1,20'h01004,20'h03000,3'h0},
      '{CAC_DISABLE_INTERRUPTS_OP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0,
        1'b1,1'b0,20'h01002,20'h03000,3'h0},
      '{CAC_DISABLE_INTERRUPTS_OP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0,
        1'b0,1'b1,20'h01002,20'h03000,3'h0},
      '{CAC_BIT_CLEAR_OP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h0,3'h2,20'h0,20'h0,
        1'b1,1'b1,20'h01004,20'h03000,3'h0},
      '{CAC_COND_JUMP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_ZERO,4'h2,3'h2,20'h3fe,20'h0,
        1'b0,1'b0,20'h00ffe,20'h03000,3'h0},
      '{CAC_COND_JUMP,CAC_MODE_REGISTER,4'h0,4'h0,CAC_JUMP_IF_NO_CARRY,4'h1,3'h2,20'h3fe,20'h0,
        1'b0,1'b0,20'h01002,20'h03000,3'h0}
    };
    rst;
    foreach (rows[i]) begin
      send(rows[i]);
      chk1("done", DONE_O, 1'b1);
      chk20("next_pc", NEXT_PC_O, rows[i].pc);
      chk20("next_sp", NEXT_SP_O, rows[i].sp);
      chk20("enables", {17'h0, PUSH_EN_O, RESULT_EN_O, FLAGS_EN_O}, {17'h0, rows[i].en});
    end
    // address add into a plain register keeps the full opcode length
    r = rows[0];
    r.dr = 4'h5;
    DST_DATA_I = 20'h00100;
    send(r);
    chk20("result", RESULT_O, 20'h00110);
    chk1("result_en", RESULT_EN_O, 1'b1);
    chk20("next_pc", NEXT_PC_O, 20'h01004);
    // enable low: the offered instruction is ignored and results stand
    CE_I = 1'b0;
    send(rows[3]);
    chk20("next_pc", NEXT_PC_O, 20'h01004);
    chk1("done", DONE_O, 1'b1);
    CE_I = 1'b1;
    // push in absolute, register, autoincrement, indirect and immediate mode directly ahead of an indexed call
    for (int k = 0; k < 5; k++) begin
      r = rows[5];
      r.md = pm[k];
      send(r);
      r.op = CAC_CALL_20BIT_OP;
      r.md = CAC_MODE_INDEXED;
      r.sr = bs[k];
      r.im = 20'h0fff0;
      send(r);
      chk20("call_addr", EFF_ADDR_O, ex[k]);
    end
    r.md = CAC_MODE_REGISTER;
    r.sr = 4'h0;
    r.ln = 3'h4;
    INSTR_ADDR_I = 20'h0a000;
    send(r);
    chk20("push_data", PUSH_DATA_O, 20'h0a002);
    INSTR_ADDR_I = 20'h01000;
    r = rows[5];
    r.op = CAC_BIT_TEST_OP;
    r.md = CAC_MODE_INDIRECT;
    r.sr = 4'h4;
    r.sd = 20'h00002;
    send(r);
    chk20("flags", {16'h0, FLAGS_O}, 20'h00002);
    r = rows[10];
    r.cd = CAC_JUMP_ALWAYS;
    r.fl = 4'h0;
    send(r);
    chk20("next_pc", NEXT_PC_O, 20'h00ffe);
    r.op = CAC_ROTATE_RIGHT_CARRY_MULTI;
    send(r);
    chk1("done", DONE_O, 1'b1);
    r = rows[11];
    send(r);
    r.op = CAC_ROTATE_LEFT_ARITH_MULTI;
    r.dr = 4'h5;
    send(r);
    chk1("done", DONE_O, 1'b1);
    chk20("result", RESULT_O, 20'h00800);
    // every condition kind except jump-always left untaken, then a rotate to the pc
    for (int k = 0; k < 7; k++) begin
      r = rows[10];
      r.cd = cac_cond_type'(3'(k));
      r.fl = nf[k];
      send(r);
      r.op = cac_op_type'(4'(8 + k % 4));
      send(r);
      chk1("done", DONE_O, 1'b0);
      chk1("halt", HALT_O, 1'b1);
      send(rows[0]);
      chk1("done", DONE_O, 1'b0);
      rst;
      chk1("halt", HALT_O, 1'b0);
    end
    end_sim;
  end
endmodule
